// ===== logic/cfst_seq.sv
// Card slot strobe sequencer: timed memory and I/O cycles with wait stretching
//
// Contract
// RULE_01: All card interface intervals count whole system clock cycles.
// RULE_02: Memory read spans 17 cycles; address 4 before strobe, 2 after.
// RULE_03: Memory read card enable 3 before strobe, 2 after release.
// RULE_04: Card asserts wait within 6 cycles of memory read strobe.
// RULE_05: Card read data valid when it releases wait, no extra delay.
// RULE_06: Memory write card enable 3 before strobe, 2 after release.
// RULE_07: Memory write data 11 before strobe release, 2 after; strobe 9.
// RULE_08: Card asserts wait within 6 cycles of memory write strobe.
// RULE_09: Memory write strobe ends at most 3 cycles after wait release.
// RULE_10: I/O read card enable 5 before strobe, 3 after release.
// RULE_11: I/O read select 6 before strobe, 4 after release.
// RULE_12: Card asserts wait within 6 cycles of I/O read strobe.
// RULE_13: Card I/O read data valid when it releases wait.
// RULE_14: I/O write card enable 5 before strobe, 3 after release.
// RULE_15: I/O write select 6 before strobe, 4 after release.
// RULE_16: I/O write data 14 before strobe release, held 3 after.
// RULE_17: Card asserts wait within 6 cycles of I/O write strobe.
// RULE_18: I/O write strobe ends within 2 cycles of wait release.
// RULE_19: I/O strobe 10 cycles in 20-cycle access, address 6 before, 4 after.
// RULE_20: Wait freezes strobe and all outputs; sequence resumes after release.
`timescale 1ns/1ns
`include "cfst_cfg.svh"
module cfst_seq (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               reqValid,
  input  wire cfst_pkg::cfst_req_t req,
  output logic                    reqReady,
  input  wire logic               cardWait,
  input  wire logic [15:0]        cardRdata,
  output logic                    cardEnable_n,
  output logic                    regSelect_n,
  output logic [10:0]             cardAddr,
  output logic [15:0]             cardWdata,
  output logic                    cardWdataOe,
  output logic                    mem_read_strobe_n,
  output logic                    mem_write_strobe_n,
  output logic                    io_read_strobe_n,
  output logic                    io_write_strobe_n,
  output logic [15:0]             rdData,
  output logic                    rdValid,
  output logic                    done
);
  import cfst_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_WAIT = 3'b100
  } cfst_state_t;

  cfst_state_t         state_q, state_d;
  cfst_req_t           req_q, req_d;
  logic [4:0]          cnt_q, cnt_d;
  cfst_ctl_t           ctl_q, ctl_d;
  logic [15:0]         rd_q, rd_d;
  logic                rdValid_q, rdValid_d;
  logic                done_q, done_d;
  logic                wr_q, wr_d;
  cfst_prof_t          prof;
  cfst_kind_t          profKind;
  logic                isIo;
  logic                isWrite;
  logic                sampleRd;

  assign profKind = (state_q == ST_IDLE) ? req.kind : req_q.kind;
  assign isIo     = req_q.kind[1];
  assign isWrite  = req_q.kind[0];

  cfst_profile uProfile (
    .kind (profKind),
    .prof (prof)
  );

  // Read data is taken one cycle before the last strobe cycle, or at the wait release
  assign sampleRd = !isWrite && !cardWait &&
                    (((state_q == ST_RUN) && (cnt_q == prof.strOff - 5'h01)) ||
                     (state_q == ST_WAIT)); // see RULE_05 RULE_13

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Counter advances one per clock cycle in ST_RUN except in the cycle that takes the wait; every edge is a count value
  always_comb begin
    state_d   = state_q;
    req_d     = req_q;
    cnt_d     = cnt_q;
    ctl_d     = ctl_q;
    rd_d      = rd_q;
    rdValid_d = 1'b0;
    done_d    = 1'b0;
    wr_d      = wr_q;
    case (state_q)
      ST_IDLE: begin
        if (reqValid && reqReady) begin
          req_d   = req;
          cnt_d   = 5'h01;
          state_d = ST_RUN;
          // Cycle 0: address, and select for I/O kinds, valid first
          ctl_d            = '0;
          ctl_d.addrValid  = 1'b1;
          ctl_d.regSelect  = req.kind[1];
          ctl_d.cardEnable = (prof.ceOn == 5'h00);
        end
      end
      ST_RUN: begin
        // Wait is honoured only while the strobe is active
        if (cardWait && (ctl_q.readStrobe || ctl_q.writeStrobe)) begin
          state_d = ST_WAIT; // see RULE_20 RULE_04 RULE_08 RULE_12 RULE_17
        end else begin
          cnt_d = cnt_q + 5'h01; // see RULE_01
          if (cnt_q == prof.ceOn)    ctl_d.cardEnable  = 1'b1;
          if (cnt_q == prof.dataOn)  ctl_d.dataDrive   = 1'b1;
          if (cnt_q == prof.strOn) begin
            ctl_d.readStrobe  = !isWrite;
            ctl_d.writeStrobe = isWrite;
          end
          if (cnt_q == prof.strOff) begin
            ctl_d.readStrobe  = 1'b0;
            ctl_d.writeStrobe = 1'b0;
          end
          if (cnt_q == prof.ceOff)   ctl_d.cardEnable  = 1'b0;
          if (cnt_q == prof.dataOff) ctl_d.dataDrive   = 1'b0;
          if (cnt_q == prof.regOff)  ctl_d.regSelect   = 1'b0;
          if (cnt_q == prof.addrOff) ctl_d.addrValid   = 1'b0;
          if (cnt_q == prof.total) begin
            ctl_d   = '0;
            done_d  = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      ST_WAIT: begin
        // Outputs frozen; on release the strobe ends at the second edge after it
        if (!cardWait) begin
          cnt_d   = prof.strOff; // see RULE_09 RULE_18
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_IDLE;
        ctl_d   = '0;
      end
    endcase
    if (sampleRd) begin
      rd_d      = cardRdata;
      rdValid_d = 1'b1;
    end
    wr_d = ctl_d.writeStrobe;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      req_q     <= '0;
      cnt_q     <= 5'h00;
      ctl_q     <= '0;
      rd_q      <= 16'h0000;
      rdValid_q <= 1'b0;
      done_q    <= 1'b0;
      wr_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      req_q     <= req_d;
      cnt_q     <= cnt_d;
      ctl_q     <= ctl_d;
      rd_q      <= rd_d;
      rdValid_q <= rdValid_d;
      done_q    <= done_d;
      wr_q      <= wr_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Register-driven pins; strobes decoded from the stored kind
  logic io_read_strobe_n_q, io_write_strobe_n_q, memRd_q, memWr_q;
  assign io_read_strobe_n_q  = ctl_q.readStrobe  &&  isIo;
  assign io_write_strobe_n_q  = ctl_q.writeStrobe &&  isIo;
  assign memRd_q = ctl_q.readStrobe  && !isIo;
  assign memWr_q = ctl_q.writeStrobe && !isIo;

  logic                ready_q;
  logic [10:0]         addr_q;
  logic [15:0]         wdat_q;
  logic [3:0]          strbN_q;
  logic                ceN_q, regN_q, oe_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ready_q <= 1'b0;
      addr_q  <= 11'h000;
      wdat_q  <= 16'h0000;
      strbN_q <= 4'hF;
      ceN_q   <= 1'b1;
      regN_q  <= 1'b1;
      oe_q    <= 1'b0;
    end else begin
      ready_q <= (state_d == ST_IDLE);
      addr_q  <= ctl_d.addrValid ? req_d.addr : 11'h000;
      wdat_q  <= ctl_d.dataDrive ? req_d.wdata : 16'h0000;
      strbN_q <= ~{ctl_d.readStrobe && !req_d.kind[1], ctl_d.writeStrobe && !req_d.kind[1],
                   ctl_d.readStrobe && req_d.kind[1], ctl_d.writeStrobe && req_d.kind[1]};
      ceN_q   <= !ctl_d.cardEnable;
      regN_q  <= !ctl_d.regSelect;
      oe_q    <= ctl_d.dataDrive;
    end
  end

  // Pins are registered from the next-state values, in step with the state; spacing is unchanged
  assign reqReady           = ready_q;
  assign cardEnable_n       = ceN_q;
  assign regSelect_n        = regN_q;
  assign cardAddr           = addr_q;
  assign cardWdata          = wdat_q;
  assign cardWdataOe        = oe_q;
  assign mem_read_strobe_n  = strbN_q[3];
  assign mem_write_strobe_n = strbN_q[2];
  assign io_read_strobe_n   = strbN_q[1];
  assign io_write_strobe_n  = strbN_q[0];
  assign rdData             = rd_q;
  assign rdValid            = rdValid_q;
  assign done               = done_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence memWrStart_s;
    $rose(memWr_q) && !cardWait;
  endsequence

  mem_wr_width_a: assert property (memWrStart_s ##1 (!cardWait)[*8] |=> $fell(memWr_q) // see RULE_07
    ) else $error("memory write strobe not 9 cycles");
  io_strobe_len_a: assert property ($rose(io_read_strobe_n_q) ##0 (!cardWait)[*8] ##1 !cardWait
    |=> io_read_strobe_n_q ##1 !io_read_strobe_n_q) else $error("I/O read strobe not 10 cycles"); // see RULE_19
  mr_ce_before_a: assert property ($rose(memRd_q) |-> $past(ctl_q.cardEnable, 3) // see RULE_03
    && !$past(ctl_q.cardEnable, 4)) else $error("card enable lead on read wrong");
  io_reg_before_a: assert property ($rose(io_write_strobe_n_q) |-> $past(ctl_q.regSelect, 6) // see RULE_15
    ) else $error("select not 6 cycles before I/O write");
  io_ce_before_a: assert property ($rose(io_read_strobe_n_q) |-> $past(ctl_q.cardEnable, 5) // see RULE_10
    && !$past(ctl_q.cardEnable, 6)) else $error("card enable lead on I/O read wrong");
  mw_ce_after_a: assert property ($fell(memWr_q) |-> ctl_q.cardEnable ##1 ctl_q.cardEnable
    ##1 !ctl_q.cardEnable) else $error("card enable hold after write wrong"); // see RULE_06
  io_data_hold_a: assert property ($fell(io_write_strobe_n_q) |-> ctl_q.dataDrive[*3] ##1 !ctl_q.dataDrive
    ) else $error("I/O write data hold wrong"); // see RULE_16
  wait_freeze_a: assert property (state_q == ST_WAIT && cardWait |=> $stable(ctl_q) // see RULE_20
    ) else $error("outputs moved during wait");
  mw_wait_rel_a: assert property (state_q == ST_WAIT && !cardWait && !isIo |-> // see RULE_09
    ##[1:3] !memWr_q) else $error("write strobe late after wait release");
  io_wait_rel_a: assert property (state_q == ST_WAIT && !cardWait && isIo && isWrite |-> // see RULE_18
    ##[1:2] !io_write_strobe_n_q) else $error("I/O write strobe late after wait release");
  mr_addr_hold_a: assert property ($fell(memRd_q) |-> ctl_q.addrValid ##1 ctl_q.addrValid
    ##1 !ctl_q.addrValid) else $error("read address hold wrong"); // see RULE_02
endmodule : cfst_seq

// ===== logic/cfst_cfg.svh
// Timing constants for the card slot strobe sequencer
`ifndef CFST_CFG_SVH
`define CFST_CFG_SVH

`define CFST_CLK_PERIOD_NS   4
`define CFST_CNT_W           5
// Common memory read (cycles of the system clock)
`define CFST_MR_CYCLE        5'h11
`define CFST_MR_ADDR_SU      5'h04
`define CFST_MR_CE_SU        5'h03
`define CFST_MR_HOLD         5'h02
// Common memory write
`define CFST_MW_CYCLE        5'h11
`define CFST_MW_ADDR_SU      5'h04
`define CFST_MW_CE_SU        5'h03
`define CFST_MW_STROBE       5'h09
`define CFST_MW_DATA_SU      5'h0B
`define CFST_MW_HOLD         5'h02
`define CFST_MW_ADDR_HOLD    5'h04
`define CFST_MW_WAIT_REL     5'h03
// I/O space read and write
`define CFST_IO_CYCLE        5'h14
`define CFST_IO_STROBE       5'h0A
`define CFST_IO_REG_SU       5'h06
`define CFST_IO_CE_SU        5'h05
`define CFST_IO_DATA_SU      5'h0E
`define CFST_IO_CE_HOLD      5'h03
`define CFST_IO_DATA_HOLD    5'h03
`define CFST_IO_REG_HOLD     5'h04
`define CFST_IO_WAIT_REL     5'h02
// Wait window after strobe start
`define CFST_WAIT_WINDOW     5'h06

`endif

// ===== logic/cfst_pkg.sv
// Types shared by the card slot strobe sequencer
package cfst_pkg;
  typedef enum logic [1:0] {
    CFST_MEM_RD = 2'h0,
    CFST_MEM_WR = 2'h1,
    CFST_IO_RD  = 2'h2,
    CFST_IO_WR  = 2'h3
  } cfst_kind_t;

  typedef struct packed {
    cfst_kind_t  kind;
    logic [10:0] addr;
    logic [15:0] wdata;
  } cfst_req_t;

  typedef struct packed {
    logic        cardEnable;
    logic        regSelect;
    logic        addrValid;
    logic        dataDrive;
    logic        readStrobe;
    logic        writeStrobe;
  } cfst_ctl_t;

  // Edge points of one access, counted from cycle start
  typedef struct packed {
    logic [4:0] addrOn;
    logic [4:0] ceOn;
    logic [4:0] regOn;
    logic [4:0] dataOn;
    logic [4:0] strOn;
    logic [4:0] strOff;
    logic [4:0] ceOff;
    logic [4:0] regOff;
    logic [4:0] dataOff;
    logic [4:0] addrOff;
    logic [4:0] total;
  } cfst_prof_t;
endpackage : cfst_pkg

// ===== logic/cfst_profile.sv
// Per-kind edge table of the card access sequence
`timescale 1ns/1ns
`include "cfst_cfg.svh"
module cfst_profile (
  input  wire cfst_pkg::cfst_kind_t kind,
  output cfst_pkg::cfst_prof_t      prof
);
  import cfst_pkg::*;

  always_comb begin
    prof = '0;
    case (kind)
      CFST_MEM_RD: begin
        // Strobe starts once address setup is met
        prof.addrOn  = 5'h00;
        prof.strOn   = `CFST_MR_ADDR_SU;
        prof.ceOn    = `CFST_MR_ADDR_SU - `CFST_MR_CE_SU; // see RULE_03
        prof.strOff  = `CFST_MR_CYCLE - `CFST_MR_HOLD; // see RULE_02
        prof.ceOff   = prof.strOff + `CFST_MR_HOLD; // see RULE_03
        prof.addrOff = prof.strOff + `CFST_MR_HOLD; // see RULE_02
        prof.regOn   = 5'h00;
        prof.regOff  = prof.addrOff;
        prof.dataOn  = `CFST_MR_CYCLE;
        prof.dataOff = `CFST_MR_CYCLE;
        prof.total   = `CFST_MR_CYCLE; // see RULE_02
      end
      CFST_MEM_WR: begin
        prof.addrOn  = 5'h00;
        prof.strOn   = `CFST_MW_ADDR_SU;
        prof.ceOn    = `CFST_MW_ADDR_SU - `CFST_MW_CE_SU; // see RULE_06
        prof.strOff  = `CFST_MW_ADDR_SU + `CFST_MW_STROBE; // see RULE_07
        prof.dataOn  = prof.strOff - `CFST_MW_DATA_SU; // see RULE_07
        prof.dataOff = prof.strOff + `CFST_MW_HOLD; // see RULE_07
        prof.ceOff   = prof.strOff + `CFST_MW_HOLD; // see RULE_06
        prof.addrOff = prof.strOff + `CFST_MW_ADDR_HOLD;
        prof.regOn   = 5'h00;
        prof.regOff  = prof.addrOff;
        prof.total   = `CFST_MW_CYCLE;
      end
      default: begin
        // I/O: strobe 10 of 20, address and select 6 before, 4 after
        prof.addrOn  = 5'h00;
        prof.regOn   = 5'h00;
        prof.strOn   = `CFST_IO_REG_SU; // see RULE_11 RULE_15 RULE_19
        prof.ceOn    = `CFST_IO_REG_SU - `CFST_IO_CE_SU; // see RULE_10 RULE_14
        prof.strOff  = `CFST_IO_REG_SU + `CFST_IO_STROBE; // see RULE_19
        prof.ceOff   = prof.strOff + `CFST_IO_CE_HOLD; // see RULE_10 RULE_14
        prof.regOff  = prof.strOff + `CFST_IO_REG_HOLD; // see RULE_11 RULE_15
        prof.addrOff = prof.strOff + `CFST_IO_REG_HOLD; // see RULE_19
        prof.dataOn  = (kind == CFST_IO_WR) ? prof.strOff - `CFST_IO_DATA_SU
                                            : `CFST_IO_CYCLE; // see RULE_16
        prof.dataOff = (kind == CFST_IO_WR) ? prof.strOff + `CFST_IO_DATA_HOLD
                                            : `CFST_IO_CYCLE; // see RULE_16
        prof.total   = `CFST_IO_CYCLE; // see RULE_19
      end
    endcase
  end
endmodule : cfst_profile

// ===== tb/cfst_card_model.sv
// Behavioural card in the slot: wait stretching and read data
`timescale 1ns/1ns
module cfst_card_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mem_read_strobe_n,
  input  wire logic        mem_write_strobe_n,
  input  wire logic        io_read_strobe_n,
  input  wire logic        io_write_strobe_n,
  input  wire logic [10:0] cardAddr,
  input  var  int          waitAt,
  input  var  int          waitLen,
  output logic             cardWait,
  output logic [15:0]      cardRdata
);
  // ----------------------------------------
  // Wait and data drive
  // ----------------------------------------
  int   cnt;
  logic anyAct;
  logic rdAct;
  logic waitNow;
  assign anyAct = !(mem_read_strobe_n & mem_write_strobe_n & io_read_strobe_n & io_write_strobe_n);
  assign rdAct  = !mem_read_strobe_n | !io_read_strobe_n;
  always @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt       = 0;
      waitNow   = 1'b0;
      cardWait  <= 1'b0;
      cardRdata <= 16'hFFFF;
    end else begin
      cnt = anyAct ? cnt + 1 : 0;
      // Raised at most 6 strobe cycles in; the bench keeps waitAt small
      waitNow = (waitLen > 0) && (cnt >= waitAt) && (cnt < waitAt + waitLen);
      // Non-blocking so the bench sampling this edge sees a settled value
      cardWait <= waitNow;
      // Word valid by the release; otherwise the last value inverted each cycle, so a stale word returns every other cycle
      cardRdata <= (rdAct && !waitNow) ? {cardAddr, 5'h0A} : ~cardRdata;
    end
  end
endmodule : cfst_card_model

// ===== tb/card_slot_strobe_timing_tb_top.sv
// Self-checking bench of the card slot strobe sequencer
`timescale 1ns/1ns
module card_slot_strobe_timing_tb_top;
  import cfst_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        sys_clk, rst, reqValid, reqReady, cardWait, cardWdataOe;
  cfst_req_t   req;
  logic [15:0] cardRdata, cardWdata, rdData, rdSeen;
  logic [10:0] cardAddr;
  logic        cardEnable_n, regSelect_n, rdValid, done, wHi;
  logic        mem_read_strobe_n, mem_write_strobe_n, io_read_strobe_n, io_write_strobe_n;
  int          waitAt, waitLen, err_count, checked, k, rel;
  int          sOn, sOff, cOn, cOff, gOn, gOff, aOn, aOff, dOn, dOff;

  cfst_seq i_cfst_seq (.sys_clk(sys_clk), .rst(rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .cardWait(cardWait), .cardRdata(cardRdata),
    .cardEnable_n(cardEnable_n), .regSelect_n(regSelect_n), .cardAddr(cardAddr),
    .cardWdata(cardWdata), .cardWdataOe(cardWdataOe), .mem_read_strobe_n(mem_read_strobe_n),
    .mem_write_strobe_n(mem_write_strobe_n), .io_read_strobe_n(io_read_strobe_n),
    .io_write_strobe_n(io_write_strobe_n), .rdData(rdData), .rdValid(rdValid), .done(done));

  cfst_card_model i_cfst_card_model (.sys_clk(sys_clk), .rst(rst),
    .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
    .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
    .cardAddr(cardAddr), .waitAt(waitAt), .waitLen(waitLen), .cardWait(cardWait),
    .cardRdata(cardRdata));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("[FAIL] %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask : chk_rng

  task automatic chk_w(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk_w

  task automatic rec(input logic low, inout int on, inout int off);
    if (low && on < 0) on = k;
    if (!low && on >= 0 && off < 0) off = k;
  endtask : rec

  // ----------------------------------------
  // One access, recorded per cycle
  // ----------------------------------------
  // Intervals are whole sys_clk cycles counted from the take
  task automatic run(input cfst_kind_t kd, input logic [10:0] ad, input logic [15:0] wd);
    int n;
    logic got;
    @(negedge sys_clk);
    reqValid = 1'b1;
    req = '{kind: kd, addr: ad, wdata: wd};
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) begin
      err_count++;
      give_verdict();
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    reqValid = 1'b0;
    {sOn, sOff, cOn, cOff, gOn, gOff, aOn, aOff, dOn, dOff, rel} = {11{-1}};
    wHi = 1'b0;
    rdSeen = 16'h0000;
    got = 1'b0;
    k = 1;
    while (!got && k < 80) begin
      rec(!(mem_read_strobe_n & mem_write_strobe_n & io_read_strobe_n & io_write_strobe_n),
          sOn, sOff);
      rec(cardEnable_n === 1'b0, cOn, cOff);
      rec(regSelect_n === 1'b0, gOn, gOff);
      rec(cardAddr !== 11'h000, aOn, aOff);
      rec(cardWdataOe === 1'b1, dOn, dOff);
      if (cardWait) wHi = 1'b1;
      else if (wHi && rel < 0) rel = k;
      if (rdValid === 1'b1) rdSeen = rdData;
      if (done === 1'b1) got = 1'b1;
      @(negedge sys_clk);
      k++;
    end
    if (!got) begin
      err_count++;
      give_verdict();
    end
  endtask : run

  task automatic chk_mem(input logic wr, input logic wt);
    chk_rng("mem addr setup", 4, 4, sOn - aOn);
    chk_rng("mem ce setup", 3, 3, sOn - cOn);
    chk_rng("mem ce hold", 2, 2, cOff - sOff);
    chk_rng("mem addr hold", wr ? 4 : 2, wr ? 4 : 2, aOff - sOff);
    if (!wt) chk_rng("mem cycle", 17, 17, aOff - aOn);
    if (!wt) chk_rng("mem strobe", wr ? 9 : 11, wr ? 9 : 11, sOff - sOn);
    if (wr && !wt) chk_rng("mem data setup", 11, 11, sOff - dOn);
    if (wr) chk_rng("mem data hold", 2, 8, dOff - sOff);
  endtask : chk_mem

  task automatic chk_io(input logic wr, input logic wt);
    chk_rng("io ce setup", 5, 5, sOn - cOn);
    chk_rng("io ce hold", 3, 3, cOff - sOff);
    chk_rng("io sel setup", 6, 6, sOn - gOn);
    chk_rng("io sel hold", 4, 4, gOff - sOff);
    chk_rng("io addr setup", 6, 6, sOn - aOn);
    chk_rng("io addr hold", 4, 4, aOff - sOff);
    if (!wt) chk_rng("io strobe", 10, 10, sOff - sOn);
    if (!wt) chk_rng("io cycle", 20, 20, aOff - aOn);
    if (wr && !wt) chk_rng("io data setup", 14, 14, sOff - dOn);
    if (wr) chk_rng("io data hold", 3, 3, dOff - sOff);
  endtask : chk_io

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_plain();
    waitLen = 0;
    run(CFST_MEM_RD, 11'h123, 16'h0000);
    chk_mem(1'b0, 1'b0);
    chk_w("mem rd data", {11'h123, 5'h0A}, rdSeen);
    run(CFST_MEM_WR, 11'h2A5, 16'hBEEF);
    chk_mem(1'b1, 1'b0);
    run(CFST_IO_RD, 11'h7FF, 16'h0000);
    chk_io(1'b0, 1'b0);
    chk_w("io rd data", {11'h7FF, 5'h0A}, rdSeen);
    run(CFST_IO_WR, 11'h001, 16'h5A5A);
    chk_io(1'b1, 1'b0);
    $display("test plain accesses finished");
  endtask : t_plain

  task automatic t_wait();
    waitAt = 2;
    waitLen = 5;
    run(CFST_MEM_RD, 11'h0F0, 16'h0000);
    chk_mem(1'b0, 1'b1);
    chk_w("mem rd wait data", {11'h0F0, 5'h0A}, rdSeen);
    run(CFST_MEM_WR, 11'h30C, 16'h1234);
    chk_mem(1'b1, 1'b1);
    chk_rng("mem wr release", 1, 3, sOff - rel);
    run(CFST_IO_RD, 11'h456, 16'h0000);
    chk_io(1'b0, 1'b1);
    chk_w("io rd wait data", {11'h456, 5'h0A}, rdSeen);
    run(CFST_IO_WR, 11'h789, 16'hC3C3);
    chk_io(1'b1, 1'b1);
    chk_rng("io wr release", 1, 2, sOff - rel);
    waitLen = 0;
    $display("test wait stretching finished");
  endtask : t_wait

  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    waitAt = 2;
    waitLen = 0;
    err_count = 0;
    checked = 0;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    t_plain();
    t_wait();
    give_verdict();
  end
endmodule : card_slot_strobe_timing_tb_top
